// >>> verilog/drv_spi_slave.sv
// Motor driver end of the serial command port
`timescale 1ns/1ps
`default_nettype none
module drv_spi_slave
  import drv_spi_pkg::*;
#(
  parameter int FILT_N = FILT_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  drv_spi_if.driver                  link,
  input  wire logic                  driver_disable_input,
  input  wire logic [9:0]            position_in,
  input  wire logic [9:0]            load_in,
  input  wire logic [4:0]            current_scale_in,
  input  wire logic [7:0]            flags_in,
  output logic [drv_spi_pkg::WORD_W-1:0] drvctrl_q,
  output logic [drv_spi_pkg::WORD_W-1:0] chopconf_q,
  output logic [drv_spi_pkg::WORD_W-1:0] smarten_q,
  output logic [drv_spi_pkg::WORD_W-1:0] sgcsconf_q,
  output logic [drv_spi_pkg::WORD_W-1:0] driver_configuration_word_q,
  output logic                       cmd_strobe_q,
  output logic                       driver_disabled_q
);
  import drv_spi_pkg::*;

  // ********************************************************************
  // Synchronise and filter the pins
  // ********************************************************************
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] filt_q;
  logic [3:0] prev_q;
  logic [3:0][7:0] stab_q;

  // Two flops before any logic; first stage read by the second only
  // Reset to the idle levels of the pins so no false edge follows reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 4'hF;
      sync_q <= 4'hF;
    end else begin
      meta_q <= {driver_disable_input, link.sdi, link.chip_select_low,
                 link.sck};
      sync_q <= meta_q;
    end
  end

  // A level is taken only after it holds FILT_N samples, so short spikes die
  // Trade-off: each filter sample adds latency on top of the two sync
  // flops, and the master half period has to cover all of it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_q <= 4'hF;
      prev_q <= 4'hF;
      stab_q <= '0;
    end else begin
      prev_q <= filt_q;
      for (int i = 0; i < 4; i++) begin
        if (sync_q[i] == filt_q[i]) begin
          stab_q[i] <= 8'h00;
        end else if (stab_q[i] >= 8'(FILT_N - 1)) begin
          filt_q[i] <= sync_q[i];
          stab_q[i] <= 8'h00;
        end else begin
          stab_q[i] <= stab_q[i] + 8'h01;
        end
      end
    end
  end

  // Edges of the filtered levels; raw pins never reach the logic below,
  // so a clock edge is acted on some four core cycles after it left
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_active;
  assign sck_rise  = filt_q[0] & ~prev_q[0];
  assign sck_fall  = ~filt_q[0] & prev_q[0];
  assign cs_rise   = filt_q[1] & ~prev_q[1];
  assign cs_active = ~filt_q[1];

  // ********************************************************************
  // Shift register and response
  // ********************************************************************
  logic [WORD_W-1:0] shreg_q;
  logic [WORD_W-1:0] resp_word;
  logic              sdo_q;
  logic              sdo_oe_q;

  // Status layout for a format code; code three falls back to the
  // position layout so a stray setting still returns something useful
  function automatic logic [WORD_W-1:0] status_layout(
    input logic [1:0] fmt,
    input logic [9:0] pos,
    input logic [9:0] load,
    input logic [4:0] scale,
    input logic [7:0] flags
  );
    logic [WORD_W-1:0] word;
    case (fmt)
      FMT_POSITION: word = {pos, 2'h0, flags};
      FMT_LOAD:     word = {load, 2'h0, flags};
      FMT_LOAD_CUR: word = {load[9:5], scale, 2'h0, flags};
      default:      word = {pos, 2'h0, flags};
    endcase
    return word;
  endfunction

  // Response layout follows the format field of the driver word
  assign resp_word = status_layout(
    driver_configuration_word_q[FMT_LSB +: 2], position_in,
    load_in, current_scale_in, flags_in);

  // Response loads at select; bits enter at LSB so top bit leaves first
  // A frame longer than twenty bits pushes the oldest bits on to data out
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg_q <= '0;
    end else if (cs_active && prev_q[1]) begin
      shreg_q <= resp_word;
    end else if (cs_active && sck_rise) begin
      shreg_q <= {shreg_q[WORD_W-2:0], filt_q[2]};
    end
  end

  // Output takes the top bit at select, then changes only on falling clock; idle line is released
  // A new bit appears about four core cycles after the clock fell
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (!cs_active) begin
      sdo_oe_q <= 1'b0;
    end else if (prev_q[1]) begin
      sdo_oe_q <= 1'b1;
      sdo_q    <= resp_word[WORD_W-1];
    end else if (sck_fall) begin
      sdo_q    <= shreg_q[WORD_W-1];
    end
  end
  assign link.sdo    = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  // ********************************************************************
  // Command latch on chip select release
  // ********************************************************************
  // Decode reads only the last twenty bits held in the shift register
  // Top two bits clear pick the drive word, else the top three bits pick
  // the slot; the two unused codes are dropped, though the strobe pulses
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      drvctrl_q                   <= '0;
      chopconf_q                  <= '0;
      smarten_q                   <= '0;
      sgcsconf_q                  <= '0;
      driver_configuration_word_q <= '0;
      cmd_strobe_q                <= 1'b0;
    end else begin
      cmd_strobe_q <= cs_rise;
      if (cs_rise) begin
        if (shreg_q[WORD_W-1 -: 2] == ADDR_DRVCTRL) begin
          drvctrl_q <= shreg_q;
        end else begin
          case (shreg_q[WORD_W-1 -: 3])
            SEL_CHOP:    chopconf_q                  <= shreg_q;
            SEL_SMART:   smarten_q                   <= shreg_q;
            SEL_SGCS:    sgcsconf_q                  <= shreg_q;
            SEL_DRVCFG:  driver_configuration_word_q <= shreg_q;
            default:     ;
          endcase
        end
      end
    end
  end

  // Disable input is filtered like the serial pins
  // Comes up disabled so the bridge stays off until the pin is seen
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      driver_disabled_q <= 1'b1;
    end else begin
      driver_disabled_q <= filt_q[3];
    end
  end
endmodule
`default_nettype wire

// >>> shared/drv_spi_pkg.sv
// Shared constants and types for the motor driver serial command port
package drv_spi_pkg;
  localparam int          WORD_W        = 20;
  localparam logic [1:0]  ADDR_DRVCTRL  = 2'h0;
  localparam logic [1:0]  ADDR_CHOP     = 2'h2;
  localparam logic [1:0]  ADDR_HIGH     = 2'h3;
  localparam logic [2:0]  SEL_CHOP      = 3'h4;
  localparam logic [2:0]  SEL_SMART     = 3'h5;
  localparam logic [2:0]  SEL_SGCS      = 3'h6;
  localparam logic [2:0]  SEL_DRVCFG    = 3'h7;
  localparam logic [1:0]  FMT_POSITION  = 2'h0;
  localparam logic [1:0]  FMT_LOAD      = 2'h1;
  localparam logic [1:0]  FMT_LOAD_CUR  = 2'h2;
  localparam int          FMT_LSB       = 4;
  localparam int          FILT_NS       = 20;
  localparam int          CLK_NS        = 20;
  // Glitch shorter than FILT_NS rejected: stable samples needed, at least 1
  localparam int          FILT_CYC      = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // A returned bit needs about six core cycles to cross the driver's
  // filter and the master's synchroniser, so a half period must be longer
  localparam int          SCK_HALF_DIV  = 8;
  typedef enum logic [4:0] {
    IDLE    = 5'h01,
    SELECT  = 5'h02,
    SHIFT   = 5'h04,
    DESEL   = 5'h08,
    GAP     = 5'h10
  } host_state_e;
endpackage

// >>> shared/drv_spi_if.sv
// Serial link between microcontroller master and motor driver port
`timescale 1ns/1ps
`default_nettype none
interface drv_spi_if;
  logic sck;
  logic chip_select_low;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport master (output sck, output chip_select_low, output sdi,
                  input sdo, input sdo_oe);
  modport driver (input sck, input chip_select_low, input sdi,
                  output sdo, output sdo_oe);
endinterface
`default_nettype wire

// >>> verilog/drv_spi_master.sv
// Microcontroller end: mode 3 master issuing 20-bit commands
`timescale 1ns/1ps
`default_nettype none
module drv_spi_master
  import drv_spi_pkg::*;
#(
  parameter int HALF_DIV = SCK_HALF_DIV,
  parameter int N_BITS   = WORD_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  drv_spi_if.master                  link,
  input  wire logic                  start,
  input  wire logic [N_BITS-1:0]     tx_word,
  output logic                       busy_q,
  output logic                       done_q,
  output logic [N_BITS-1:0]          rx_word_q
);
  import drv_spi_pkg::*;

  // ********************************************************************
  // Transfer sequencer
  // ********************************************************************
  host_state_e state_q;
  logic [7:0]        div_q;
  logic [7:0]        bit_q;
  logic [N_BITS-1:0] tx_q;
  logic              sck_q;
  logic              cs_q;
  logic [1:0]        sdo_meta_q;
  logic [1:0]        sdo_sync_q;
  logic              tick;

  // Half period of HALF_DIV core cycles; it must outlast the round trip
  assign tick = (div_q == 8'(HALF_DIV - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_meta_q <= 2'h0;
      sdo_sync_q <= 2'h0;
    end else begin
      sdo_meta_q <= {link.sdo_oe, link.sdo};
      sdo_sync_q <= sdo_meta_q;
    end
  end

  // Clock idles high; data changes on falling, slave samples on rising
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= IDLE;
      div_q     <= 8'h00;
      bit_q     <= 8'h00;
      tx_q      <= '0;
      sck_q     <= 1'b1;
      cs_q      <= 1'b1;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      rx_word_q <= '0;
    end else begin
      done_q <= 1'b0;
      div_q  <= tick ? 8'h00 : div_q + 8'h01;
      case (state_q)
        IDLE: begin
          div_q <= 8'h00;
          if (start) begin
            tx_q    <= tx_word;
            cs_q    <= 1'b0;
            busy_q  <= 1'b1;
            bit_q   <= 8'h00;
            state_q <= SELECT;
          end
        end
        SELECT: if (tick) begin
          sck_q   <= 1'b0;
          state_q <= SHIFT;
        end
        SHIFT: if (tick) begin
          if (!sck_q) begin
            sck_q     <= 1'b1;
            rx_word_q <= {rx_word_q[N_BITS-2:0], sdo_sync_q[0]};
            if (bit_q == 8'(N_BITS - 1)) begin
              state_q <= DESEL;
            end else begin
              bit_q <= bit_q + 8'h01;
            end
          end else begin
            sck_q <= 1'b0;
            tx_q  <= {tx_q[N_BITS-2:0], 1'b0};
          end
        end
        DESEL: if (tick) begin
          cs_q    <= 1'b1;
          state_q <= GAP;
        end
        GAP: if (tick) begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  assign link.sck             = sck_q;
  assign link.chip_select_low = cs_q;
  assign link.sdi             = tx_q[N_BITS-1];
endmodule
`default_nettype wire

// >>> verif/drv_spi_checker.sv
// Concurrent checks on the serial link between master and driver port
`timescale 1ns/1ps
`default_nettype none
module drv_spi_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic chip_select_low,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ************************************************************
  // Link framing and output enable
  // ************************************************************
  a_oe_on_select: assert property (
    $fell(chip_select_low) |-> ##[1:8] sdo_oe)
    else $error("sdo not driven after select");
  a_oe_off_deselect: assert property (
    $rose(chip_select_low) |-> ##[1:8] !sdo_oe)
    else $error("sdo still driven after deselect");
  a_quiet_when_idle: assert property (
    chip_select_low [*8] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  a_clock_idle_high: assert property (
    chip_select_low |-> sck)
    else $error("serial clock low outside frame");
  a_select_clock_apart: assert property (
    $changed(chip_select_low) |-> sck && $past(sck))
    else $error("select moved near a clock edge");
  a_gap_min: assert property (
    $rose(chip_select_low) |=> chip_select_low [*3])
    else $error("select high gap too short");
  // Half periods must leave the resynchroniser room to see each level
  a_low_min: assert property (
    $fell(sck) |=> !sck [*3])
    else $error("serial clock low phase too short");
  // Data out must already be settled when the clock rises, not move there
  a_sdo_hold_high: assert property (
    $rose(sck) && !chip_select_low |-> (!sdo_oe || $stable(sdo)) [*7])
    else $error("sdo moved while clock high");
  c_frame: cover property ($rose(chip_select_low));
  c_bit: cover property ($fell(sck) && !chip_select_low);
  c_drive: cover property ($rose(sdo_oe));
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Bench: two master/driver pairs, 20-bit and 40-bit chained frames
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import drv_spi_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic [1:0]  start    = 2'h0;
  logic [19:0] tx0      = 20'h0;
  logic [39:0] tx1      = 40'h0;
  logic        dis_in   = 1'b1;
  logic [9:0]  pos      = 10'h0;
  logic [9:0]  load     = 10'h0;
  logic [4:0]  cur      = 5'h0;
  logic [7:0]  flags    = 8'h0;
  logic [1:0]  done, strobe, disabled, busy;
  logic [19:0] rx0;
  logic [39:0] rx1;
  logic [19:0] r0 [5];
  logic [19:0] r1 [5];
  logic [19:0] m [2][5];
  int          nstb [2];
  int          n_errors = 0;
  int          cmp_count = 0;
  int unsigned lfsr = 28;
  always #10 core_clk = ~core_clk;
  drv_spi_if l0 ();
  drv_spi_if l1 ();
  drv_spi_checker u_drv_spi_checker (.core_clk(core_clk), .reset_n(reset_n),
    .sck(l0.sck), .chip_select_low(l0.chip_select_low), .sdi(l0.sdi),
    .sdo(l0.sdo), .sdo_oe(l0.sdo_oe));
  drv_spi_master u_drv_spi_master (.core_clk(core_clk), .reset_n(reset_n),
    .link(l0), .start(start[0]), .tx_word(tx0), .busy_q(busy[0]),
    .done_q(done[0]),
    .rx_word_q(rx0));
  // Second master shifts two words so the driver acts as a chain stage
  drv_spi_master #(.N_BITS(40)) u_drv_spi_master_b (.core_clk(core_clk),
    .reset_n(reset_n), .link(l1), .start(start[1]), .tx_word(tx1),
    .busy_q(busy[1]), .done_q(done[1]), .rx_word_q(rx1));
  drv_spi_slave u_drv_spi_slave (.core_clk(core_clk), .reset_n(reset_n),
    .link(l0), .driver_disable_input(dis_in), .position_in(pos),
    .load_in(load), .current_scale_in(cur), .flags_in(flags),
    .drvctrl_q(r0[0]), .chopconf_q(r0[1]), .smarten_q(r0[2]),
    .sgcsconf_q(r0[3]), .driver_configuration_word_q(r0[4]),
    .cmd_strobe_q(strobe[0]), .driver_disabled_q(disabled[0]));
  drv_spi_slave u_drv_spi_slave_b (.core_clk(core_clk), .reset_n(reset_n),
    .link(l1), .driver_disable_input(dis_in), .position_in(pos),
    .load_in(load), .current_scale_in(cur), .flags_in(flags),
    .drvctrl_q(r1[0]), .chopconf_q(r1[1]), .smarten_q(r1[2]),
    .sgcsconf_q(r1[3]), .driver_configuration_word_q(r1[4]),
    .cmd_strobe_q(strobe[1]), .driver_disabled_q(disabled[1]));
  // Count command strobes of each driver
  always @(posedge core_clk) begin
    for (int p = 0; p < 2; p++) if (strobe[p] === 1'b1) nstb[p]++;
  end
  function automatic int unsigned nxt(int unsigned v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Response layout picked by the format field of the driver word
  function automatic logic [19:0] resp(logic [19:0] conf);
    case (conf[5:4])
      2'h1: return {load, 2'h0, flags};
      2'h2: return {load[9:5], cur, 2'h0, flags};
      default: return {pos, 2'h0, flags};
    endcase
  endfunction
  // Target slot from the top three bits; -1 means ignored
  function automatic int tgt(logic [19:0] w);
    case (w[19:17])
      3'h4: return 1;
      3'h5: return 2;
      3'h6: return 3;
      3'h7: return 4;
      3'h2, 3'h3: return -1;
      default: return 0;
    endcase
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One frame on pair p; status inputs change only between frames
  task automatic xfer(input int p, input logic [39:0] w);
    logic [39:0] er;
    int          t;
    lfsr = nxt(lfsr);
    @(posedge core_clk);
    {flags, cur, load, pos} <= {lfsr[31:24], lfsr[4:0], lfsr[23:10], 6'h0};
    @(posedge core_clk);
    er = (p == 0) ? {20'h0, resp(m[0][4])} : {resp(m[1][4]), w[39:20]};
    if (p == 0) tx0 <= w[19:0];
    else tx1 <= w;
    start[p] <= 1'b1;
    @(posedge core_clk);
    start[p] <= 1'b0;
    @(negedge core_clk);
    check(busy[p], 1'b1);
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (done[p] !== 1'b1 && t < 1000);
    // A frame that never finishes counts here as a mismatch
    check(done[p], 1'b1);
    check(busy[p], 1'b0);
    check(p ? rx1 : {20'h0, rx0}, er);
    if (tgt(w[19:0]) >= 0) m[p][tgt(w[19:0])] = w[19:0];
    repeat (10) @(negedge core_clk);
    for (int i = 0; i < 5; i++) begin
      check(p ? r1[i] : r0[i], m[p][i]);
    end
  endtask
  // Main sequence
  initial begin
    m = '{default: 20'h0};
    nstb = '{0, 0};
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    dis_in <= 1'b0;
    for (int k = 0; k < 8; k++) xfer(0, {20'h0, 3'(k), 17'(lfsr)});
    for (int f = 0; f < 4; f++) begin
      xfer(0, {20'h0, 3'h7, 11'(lfsr), 2'(f), 4'h0});
      xfer(0, {20'h0, 3'h4, 17'(lfsr)});
    end
    check(nstb[0], 16);
    $display("test short frames done");
    for (int k = 0; k < 8; k++) xfer(1, {20'(lfsr), 3'(k), 17'(nxt(lfsr))});
    check(nstb[1], 8);
    $display("test chained frames done");
    @(posedge core_clk);
    dis_in <= 1'b1;
    repeat (8) @(negedge core_clk);
    check(disabled, 2'h3);
    @(posedge core_clk);
    dis_in <= 1'b0;
    repeat (8) @(negedge core_clk);
    check(disabled, 2'h0);
    $display("test disable input done");
    tally_and_finish();
  end
  // Watchdog well beyond the 24 frames of at most about 700 cycles each
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
